/* File: rtl/imps_pkg.sv */
package imps_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 8;
  // straps settle through the pin synchroniser before they are latched
  localparam int STRAP_SETTLE_NS = 32;
  localparam int STRAP_SETTLE_CYC = (STRAP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest gap between external clock edges before the clock is reported lost
  localparam int EXT_CLK_LOSS_NS = 1000;
  localparam int EXT_CLK_LOSS_CYC = EXT_CLK_LOSS_NS / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // ==========================================================================
  // reset values
  // ==========================================================================
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [2:0] SPI_RST = 3'h4;
  localparam logic [4:0] CFG_RST = 5'h00;

  // ==========================================================================
  // strap field positions within cfg
  // ==========================================================================
  localparam int CFG_STRAP0 = 0;
  localparam int CFG_STRAP1 = 1;
  localparam int CFG_STRAP2 = 2;
  localparam int CFG_STRAP3 = 3;
  localparam int CFG_STRAP4 = 4;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic spi;
    logic uart;
    logic standalone;
    logic ext_step;
  } imps_mode_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic mosi;
  } imps_spi_t;

  typedef struct packed {
    logic left;
    logic right;
  } imps_ref_t;

  typedef enum logic [1:0] {
    ST_SETTLE = 2'b01,
    ST_RUN = 2'b10
  } imps_state_t;

endpackage

/* File: rtl/imps_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module imps_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // data
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] stage_q [STAGES];

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= '0;
      end
    end else begin
      stage_q[0] <= d_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign q_o = stage_q[STAGES-1];

endmodule

`default_nettype wire

/* File: rtl/imps_clk_mon.sv */
`timescale 1ns/1ps
`default_nettype none

module imps_clk_mon
  import imps_pkg::*;
#(
  parameter int LOSS_CYC = EXT_CLK_LOSS_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // synchronised external clock level
  input wire logic ext_lvl_i,
  // external clock is toggling
  output logic active_o
);

  localparam int CW = $clog2(LOSS_CYC + 1);
  localparam logic [CW-1:0] LOSS_MAX = CW'(LOSS_CYC);

  logic prev_q;
  logic [CW-1:0] gap_q;
  logic edge_s;

  assign edge_s = ext_lvl_i ^ prev_q;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= ext_lvl_i;
    end
  end

  // cycles since the last edge, saturating at the loss limit
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gap_q <= LOSS_MAX;
    end else if (edge_s) begin
      gap_q <= '0;
    end else if (gap_q != LOSS_MAX) begin
      gap_q <= gap_q + CW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      active_o <= 1'b0;
    end else begin
      active_o <= edge_s || (gap_q < LOSS_MAX - CW'(1));
    end
  end

endmodule

`default_nettype wire

/* File: rtl/imps_pin_select.sv */
`timescale 1ns/1ps
`default_nettype none

// Contract
// - step source low uses internal ramp steps
// - step source high uses external step/dir
// - both selects low enables UART
// - serial low, step high: standalone straps
// - serial select high enables SPI pins
// - serial select defaults low via pulldown
// - chip select is active low
// - SPI data out tri-states when deselected
// - UART: data pins carry chain address
// - external clock monitored; loss reported on ext_clk_active_o
// - shared pins: switches or step/dir
// - shared pin: encoder B or speed enable
module imps_pin_select
  import imps_pkg::*;
#(
  parameter int LOSS_CYC = EXT_CLK_LOSS_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // mode straps
  input wire logic step_source_select_i,
  input wire logic serial_port_select_i,
  // shared pins
  input wire logic chip_select_or_strap3_i,
  input wire logic serial_clock_or_strap2_i,
  input wire logic serial_in_or_strap1_i,
  input wire logic serial_out_or_strap0_i,
  input wire logic left_switch_or_step_in_i,
  input wire logic right_switch_or_direction_in_i,
  input wire logic encoder_b_or_speed_ctl_enable_i,
  input wire logic factory_test_select_i,
  input wire logic ext_clk_pin_i,
  // internal sources
  input wire logic ramp_step_i,
  input wire logic ramp_dir_i,
  input wire logic spi_miso_i,
  input wire logic chain_address_link_i,
  // pin drive
  output logic serial_out_or_strap0_o,
  output logic serial_out_or_strap0_oe_o,
  output logic serial_port_select_pd_o,
  // to internal logic
  output imps_mode_t mode_o,
  output imps_spi_t spi_o,
  output logic [4:0] cfg_o,
  output logic chain_address_in_o,
  output imps_ref_t ref_o,
  output logic drv_step_o,
  output logic drv_dir_o,
  output logic encoder_b_o,
  output logic speed_ctl_en_o,
  output logic ext_clk_active_o,
  output logic factory_test_o
);

  // ==========================================================================
  // pin synchronisers
  // ==========================================================================
  localparam int NPIN = 10;
  localparam int CW = $clog2(STRAP_SETTLE_CYC + 1);
  localparam logic [CW-1:0] SETTLE_MAX = CW'(STRAP_SETTLE_CYC);

  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_s;
  logic sd_s, spim_s, cs_s, sck_s, sdi_s, sdo_s, left_s, right_s, encb_s, tst_s;

  assign pin_raw = {step_source_select_i, serial_port_select_i, chip_select_or_strap3_i,
                    serial_clock_or_strap2_i, serial_in_or_strap1_i, serial_out_or_strap0_i,
                    left_switch_or_step_in_i, right_switch_or_direction_in_i,
                    encoder_b_or_speed_ctl_enable_i, factory_test_select_i};
  assign {sd_s, spim_s, cs_s, sck_s, sdi_s, sdo_s, left_s, right_s, encb_s, tst_s} = pin_s;

  imps_sync #(
    .WIDTH(NPIN),
    .STAGES(SYNC_STAGES)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  // ==========================================================================
  // external clock loss detection
  // ==========================================================================
  logic ext_clk_s;
  logic ext_active_s;

  imps_sync #(
    .WIDTH(1),
    .STAGES(SYNC_STAGES)
  ) u_clk_sync (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .d_i(ext_clk_pin_i),
    .q_o(ext_clk_s)
  );

  imps_clk_mon #(
    .LOSS_CYC(LOSS_CYC)
  ) u_clk_mon (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .ext_lvl_i(ext_clk_s),
    .active_o(ext_active_s)
  );

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_clk_active_o <= 1'b0;
    end else begin
      ext_clk_active_o <= ext_active_s;
    end
  end

  // ==========================================================================
  // strap latch
  // ==========================================================================
  imps_state_t state_q;
  logic [CW-1:0] settle_q;

  function automatic imps_mode_t decode_mode(input logic sd, input logic spim);
    imps_mode_t m;
    m.spi = spim;
    m.uart = !spim && !sd;
    m.standalone = !spim && sd;
    m.ext_step = sd;
    return m;
  endfunction

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_SETTLE;
      settle_q <= '0;
    end else begin
      case (state_q)
        ST_SETTLE: begin
          settle_q <= settle_q + CW'(1);
          if (settle_q == SETTLE_MAX - CW'(1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
        default: begin
          state_q <= ST_SETTLE;
          settle_q <= '0;
        end
      endcase
    end
  end

  // mode captured once, at the end of settling
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_o <= MODE_RST;
    end else if (state_q == ST_SETTLE && settle_q == SETTLE_MAX - CW'(1)) begin
      mode_o <= decode_mode(sd_s, spim_s);
    end
  end

  logic run_s;
  assign run_s = (state_q == ST_RUN);

  // pad pulldown keeps an open select pin at the non-SPI choice
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_port_select_pd_o <= 1'b1;
    end else begin
      serial_port_select_pd_o <= 1'b1;
    end
  end

  // ==========================================================================
  // host interface routing
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      spi_o <= SPI_RST;
    end else if (run_s && mode_o.spi) begin
      spi_o <= '{cs_n: cs_s, sck: sck_s, mosi: sdi_s};
    end else begin
      spi_o <= SPI_RST;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      chain_address_in_o <= 1'b0;
    end else begin
      chain_address_in_o <= run_s && mode_o.uart && sdi_s;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cfg_o <= CFG_RST;
    end else if (run_s && mode_o.standalone) begin
      cfg_o[CFG_STRAP0] <= sdo_s;
      cfg_o[CFG_STRAP1] <= sdi_s;
      cfg_o[CFG_STRAP2] <= sck_s;
      cfg_o[CFG_STRAP3] <= cs_s;
      cfg_o[CFG_STRAP4] <= encb_s;
    end else begin
      cfg_o <= CFG_RST;
    end
  end

  // data out pin: SPI data while selected, chain link in UART, input otherwise
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_out_or_strap0_o <= 1'b0;
      serial_out_or_strap0_oe_o <= 1'b0;
    end else if (run_s && mode_o.spi) begin
      serial_out_or_strap0_o <= spi_miso_i;
      serial_out_or_strap0_oe_o <= !cs_s;
    end else if (run_s && mode_o.uart) begin
      serial_out_or_strap0_o <= chain_address_link_i;
      serial_out_or_strap0_oe_o <= 1'b1;
    end else begin
      serial_out_or_strap0_o <= 1'b0;
      serial_out_or_strap0_oe_o <= 1'b0;
    end
  end

  // ==========================================================================
  // motion pin routing
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      drv_step_o <= 1'b0;
      drv_dir_o <= 1'b0;
    end else if (!run_s) begin
      drv_step_o <= 1'b0;
      drv_dir_o <= 1'b0;
    end else if (mode_o.ext_step) begin
      drv_step_o <= left_s;
      drv_dir_o <= right_s;
    end else begin
      drv_step_o <= ramp_step_i;
      drv_dir_o <= ramp_dir_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_o <= '0;
    end else begin
      ref_o <= '{left: run_s && !mode_o.ext_step && left_s,
                 right: run_s && !mode_o.ext_step && right_s};
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      encoder_b_o <= 1'b0;
      speed_ctl_en_o <= 1'b0;
    end else begin
      encoder_b_o <= run_s && !mode_o.ext_step && encb_s;
      speed_ctl_en_o <= run_s && mode_o.ext_step && mode_o.spi && encb_s;
    end
  end

  // test select is held low by the board; reported only
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      factory_test_o <= 1'b0;
    end else begin
      factory_test_o <= tst_s;
    end
  end

  // ==========================================================================
  // assertions
  // ==========================================================================
  localparam int QW = $clog2(LOSS_CYC + 2);
  logic ext_prev_q;
  logic [QW-1:0] quiet_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_prev_q <= 1'b0;
      quiet_q <= '0;
    end else begin
      ext_prev_q <= ext_clk_s;
      if (ext_clk_s != ext_prev_q) begin
        quiet_q <= '0;
      end else if (quiet_q != QW'(LOSS_CYC + 1)) begin
        quiet_q <= quiet_q + QW'(1);
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  mode_onehot_a: assert property (run_s |-> $onehot({mode_o.spi, mode_o.uart, mode_o.standalone}))
    else $error("mode not one of spi, uart, standalone");
  mode_stable_a: assert property (run_s && $past(run_s) |-> $stable(mode_o))
    else $error("mode changed during operation");
  int_step_a: assert property (run_s && !mode_o.ext_step |=> drv_step_o == $past(ramp_step_i))
    else $error("internal step not routed");
  ext_step_a: assert property (run_s && mode_o.ext_step |=> drv_dir_o == $past(right_s))
    else $error("external direction not routed");
  uart_sel_a: assert property (mode_o.uart |-> !mode_o.ext_step && !mode_o.spi)
    else $error("uart mode with wrong straps");
  standalone_cfg_a: assert property (run_s && !mode_o.standalone |=> cfg_o == CFG_RST)
    else $error("straps passed outside standalone");
  spi_idle_a: assert property (!(run_s && mode_o.spi) |=> spi_o.cs_n)
    else $error("chip select active outside spi");
  sdo_tristate_a: assert property (run_s && mode_o.spi && cs_s |=> !serial_out_or_strap0_oe_o)
    else $error("data out driven while deselected");
  chain_out_a: assert property (run_s && mode_o.uart |=> serial_out_or_strap0_oe_o
                                && serial_out_or_strap0_o == $past(chain_address_link_i))
    else $error("chain address not driven");
  clk_loss_a: assert property (quiet_q >= QW'(LOSS_CYC) |=> !ext_clk_active_o)
    else $error("external clock still reported after loss");
  ref_route_a: assert property (run_s && mode_o.ext_step |=> ref_o == '0)
    else $error("reference switches active in step/dir mode");
  speed_en_a: assert property (!(mode_o.spi && mode_o.ext_step) |=> !speed_ctl_en_o)
    else $error("speed enable outside both-high mode");
  pulldown_a: assert property (serial_port_select_pd_o)
    else $error("select pulldown released");
  settle_a: assert property ($rose(rstn_i) |-> state_q == ST_SETTLE)
    else $error("straps latched before settling");

  spi_cov_c: cover property (run_s && mode_o.spi && !cs_s);
  uart_cov_c: cover property (run_s && mode_o.uart);
  standalone_cov_c: cover property (run_s && mode_o.standalone);
  clk_fail_cov_c: cover property (ext_clk_active_o ##1 !ext_clk_active_o);

endmodule

`default_nettype wire

/* File: test/imps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none

module imps_host_model (
  // clock
  input wire logic clk_i,
  // host active, else pins carry strap levels {cs, sck, sdi}
  input wire logic en_i,
  input wire logic [2:0] strap_i,
  // data-out wire level
  input wire logic sdo_i,
  // pins toward the device
  output logic cs_n_o,
  output logic sck_o,
  output logic mosi_o
);
  logic cs_q = 1'b1;
  logic sck_q = 1'b0;
  logic mosi_q = 1'b0;
  logic tog_q = 1'b0;

  // ==========================================================================
  // pin drive
  // ==========================================================================
  // released data line changes every cycle so a stale value is never seen
  always @(posedge clk_i) begin
    tog_q <= ~tog_q;
  end

  assign cs_n_o = en_i ? cs_q : strap_i[2];
  assign sck_o = en_i ? sck_q : strap_i[1];
  assign mosi_o = en_i ? (cs_q ? tog_q : mosi_q) : strap_i[0];

  // ==========================================================================
  // host tasks
  // ==========================================================================
  task automatic sel(input logic lvl);
    @(posedge clk_i);
    cs_q <= lvl;
  endtask

  // mode 0 shift, slow clock; data read back on each rising serial clock
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      @(posedge clk_i);
      mosi_q <= tx[i];
      repeat (4) @(posedge clk_i);
      sck_q <= 1'b1;
      rx[i] = sdo_i;
      repeat (4) @(posedge clk_i);
      sck_q <= 1'b0;
    end
  endtask
endmodule

`default_nettype wire

/* File: test/tb_interface_mode_pin_select.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module tb_interface_mode_pin_select;
  import imps_pkg::*;
  localparam int LOSS_P = 16;

  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sd_sel = 1'b0, sp_sel = 1'b0, host_en = 1'b0, sdo_strap = 1'b0, sp_float = 1'b1;
  logic [2:0] straps = 3'h0;
  logic left = 1'b0, right = 1'b0, encb = 1'b0, ext_clk = 1'b0;
  logic ramp_step = 1'b0, ramp_dir = 1'b0, miso = 1'b0, link = 1'b0;
  wire cs_n, sck, mosi, sdo_pin, sp_pin;
  logic sdo_o, sdo_oe, pd, chain_in, drv_step, drv_dir, enc_b, spd_en, clk_act, tst;
  imps_mode_t mode;
  imps_spi_t spi;
  imps_ref_t refs;
  logic [4:0] cfg;
  int n_fail = 0;
  int samples_checked = 0;

  always #4 clk = ~clk;

  // data-out wire: device when enabled, else the strap level, or the wrong bit while a host listens
  assign sdo_pin = sdo_oe ? sdo_o : (host_en ? ~miso : sdo_strap);
  // open select pin resolves only through the pad pulldown
  assign sp_pin = sp_float ? (pd ? 1'b0 : 1'bx) : sp_sel;

  imps_host_model u_imps_host_model (
    .clk_i(clk), .en_i(host_en), .strap_i(straps), .sdo_i(sdo_pin),
    .cs_n_o(cs_n), .sck_o(sck), .mosi_o(mosi)
  );

  imps_pin_select #(.LOSS_CYC(LOSS_P)) u_imps_pin_select (
    .clk_i(clk), .rstn_i(rst_n), .step_source_select_i(sd_sel), .serial_port_select_i(sp_pin),
    .chip_select_or_strap3_i(cs_n), .serial_clock_or_strap2_i(sck), .serial_in_or_strap1_i(mosi),
    .serial_out_or_strap0_i(sdo_pin), .left_switch_or_step_in_i(left),
    .right_switch_or_direction_in_i(right), .encoder_b_or_speed_ctl_enable_i(encb),
    .factory_test_select_i(1'b0),
    .ext_clk_pin_i(ext_clk), .ramp_step_i(ramp_step), .ramp_dir_i(ramp_dir), .spi_miso_i(miso),
    .chain_address_link_i(link), .serial_out_or_strap0_o(sdo_o), .serial_out_or_strap0_oe_o(sdo_oe),
    .serial_port_select_pd_o(pd), .mode_o(mode), .spi_o(spi), .cfg_o(cfg), .chain_address_in_o(chain_in),
    .ref_o(refs), .drv_step_o(drv_step), .drv_dir_o(drv_dir), .encoder_b_o(enc_b),
    .speed_ctl_en_o(spd_en), .ext_clk_active_o(clk_act), .factory_test_o(tst)
  );

  // ==========================================================================
  // helpers
  // ==========================================================================
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic boot(input logic sd, input logic sp, input int hold);
    @(posedge clk);
    rst_n <= 1'b0;
    sd_sel <= sd;
    sp_sel <= sp;
    sp_float <= !sp;
    host_en <= sp;
    repeat (hold) @(posedge clk);
    rst_n <= 1'b1;
    wt(8);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // scenarios
  // ==========================================================================
  task automatic t_uart();
    boot(1'b0, 1'b0, 20);
    `CHK(mode, 4'b0100)
    `CHK(pd, 1'b1)
    `CHK(spi, 3'b100)
    `CHK(tst, 1'b0)
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      straps <= {2'b10, v[0]};
      link <= ~v[0];
      ramp_step <= v[0];
      ramp_dir <= ~v[0];
      left <= v[0];
      right <= ~v[0];
      encb <= v[0];
      wt(4);
      `CHK(chain_in, v[0])
      `CHK(sdo_pin, ~v[0])
      `CHK(sdo_oe, 1'b1)
      `CHK(drv_step, v[0])
      `CHK(drv_dir, ~v[0])
      `CHK(refs, {v[0], ~v[0]})
      `CHK(enc_b, v[0])
      `CHK(spd_en, 1'b0)
    end
    @(posedge clk);
    sp_sel <= 1'b1;
    sp_float <= 1'b0;
    sd_sel <= 1'b1;
    wt(8);
    `CHK(mode, 4'b0100)
  endtask

  task automatic t_spi();
    logic [7:0] rx;
    boot(1'b0, 1'b1, 2);
    `CHK(mode, 4'b1000)
    `CHK(sdo_oe, 1'b0)
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      miso <= v[0];
      u_imps_host_model.sel(1'b0);
      wt(4);
      `CHK(spi.cs_n, 1'b0)
      `CHK(sdo_oe, 1'b1)
      u_imps_host_model.shift(8'h5a ^ {8{v[0]}}, rx);
      wt(4);
      `CHK(rx, {8{v[0]}})
      `CHK(spi.mosi, v[0])
      `CHK(spi.sck, 1'b0)
      u_imps_host_model.sel(1'b1);
      wt(4);
      `CHK(spi.cs_n, 1'b1)
      `CHK(sdo_oe, 1'b0)
    end
  endtask

  task automatic t_stand();
    boot(1'b1, 1'b0, 2);
    `CHK(mode, 4'b0011)
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      straps <= v[0] ? 3'b101 : 3'b010;
      sdo_strap <= v[0];
      encb <= ~v[0];
      left <= v[0];
      right <= ~v[0];
      ramp_step <= ~v[0];
      ramp_dir <= v[0];
      wt(4);
      `CHK(cfg, v[0] ? 5'h0b : 5'h14)
      `CHK(sdo_oe, 1'b0)
      `CHK(drv_step, v[0])
      `CHK(drv_dir, ~v[0])
      `CHK(refs, 2'b00)
      `CHK(enc_b, 1'b0)
      `CHK(spd_en, 1'b0)
    end
  endtask

  task automatic t_spi_ext();
    boot(1'b1, 1'b1, 2);
    `CHK(mode, 4'b1001)
    for (int v = 0; v < 2; v++) begin
      @(posedge clk);
      encb <= v[0];
      left <= ~v[0];
      right <= v[0];
      wt(4);
      `CHK(spd_en, v[0])
      `CHK(enc_b, 1'b0)
      `CHK(drv_step, ~v[0])
      `CHK(drv_dir, v[0])
      `CHK(cfg, 5'h00)
    end
  endtask

  task automatic t_clk();
    int n;
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      ext_clk <= ~ext_clk;
      @(posedge clk);
    end
    wt(4);
    `CHK(clk_act, 1'b1)
    n = 0;
    while (clk_act === 1'b1 && n < LOSS_P + 16) begin
      wt(1);
      n++;
    end
    if (clk_act !== 1'b0) begin
      n_fail++;
      $display("[ERR] %0t clock loss not flagged", $time);
      stop_test();
    end
    `CHK(n > LOSS_P - 8, 1'b1)
    @(posedge clk);
    ext_clk <= ~ext_clk;
    wt(6);
    `CHK(clk_act, 1'b1)
  endtask

  initial begin
    t_uart();
    t_spi();
    t_stand();
    t_spi_ext();
    t_clk();
    stop_test();
  end
endmodule

`default_nettype wire
